// file: pkg/scsihp_pkg.sv
/*
  shared constants of the scsi controller host/dma port: device register
  indices, field positions, modes, status codes, host command registers.
  assumes nothing beyond a systemverilog compiler.
*/
package scsihp_pkg;
  // device register indices reached through the address pointer
  localparam logic [4:0]  REG_CTRL    = 5'h01;
  localparam logic [4:0]  REG_OFFSET  = 5'h02;
  localparam logic [4:0]  REG_CNT_HI  = 5'h03;
  localparam logic [4:0]  REG_CNT_LO  = 5'h04;
  localparam logic [4:0]  REG_STATUS  = 5'h05;
  localparam logic [4:0]  REG_DATA    = 5'h06;
  localparam logic [4:0]  REG_ERR     = 5'h07;
  // control register fields
  localparam int          CTRL_MODE   = 0;
  localparam int          CTRL_PAR_EN = 2;
  localparam int          CTRL_DIR    = 3;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  // transfer modes
  localparam logic [1:0]  MODE_PIO    = 2'h0;
  localparam logic [1:0]  MODE_DMA    = 2'h1;
  localparam logic [1:0]  MODE_BURST  = 2'h2;
  localparam logic [1:0]  MODE_BUF    = 2'h3;
  // synchronous offset and burst count limits
  localparam logic [3:0]  OFFSET_MIN  = 4'h1;
  localparam logic [3:0]  OFFSET_MAX  = 4'hC;
  localparam logic [12:0] COUNT_MAX   = 13'h1000;
  // status codes for scsi engine events that bring no status of their own
  localparam logic [7:0]  STAT_SEL    = 8'h11;
  localparam logic [7:0]  STAT_PHASE  = 8'h88;
  // host command registers
  localparam logic [2:0]  H_ADDR      = 3'h0;
  localparam logic [2:0]  H_WDATA     = 3'h1;
  localparam logic [2:0]  H_CTRL      = 3'h2;
  localparam logic [2:0]  H_GO        = 3'h3;
  localparam logic [2:0]  H_STATUS    = 3'h4;
  localparam logic [2:0]  H_RDATA     = 3'h5;
  localparam int          HC_MUX      = 0;
  localparam int          HC_BUF      = 1;
  localparam int          HC_DMA      = 2;
  localparam int          HC_DMA_WR   = 3;
  localparam int          HC_PERMIT   = 4;
  localparam int          HC_SOFTRST  = 5;
  localparam int          GO_RD       = 0;
  localparam int          GO_WR       = 1;
  // last cycle index of a host strobe (strobes last three cycles)
  localparam logic [1:0]  HOLD_LAST   = 2'h2;
endpackage

// file: pkg/scsihp_if.sv
/*
  pins between the controller port (dev) and its processor/dma partner (host).
  each two-way pin has one drive and enable per end; the wire level is
  resolved here, with the pull-up level when nobody drives.
*/
`timescale 1ns/100ps
`default_nettype none
interface scsihp_if;
  logic [7:0] data_h, data_d, data;
  logic       data_h_oe, data_d_oe, dp_h, dp_d, dp;
  logic       rs_h, rs_h_oe, rs_d, rs_d_oe, read_strobe_n;
  logic       ws_h, ws_h_oe, ws_d, ws_d_oe, write_strobe_n;
  logic       ack_h, ack_h_oe, sel_d, sel_d_oe, dma_ack_n;
  logic       drq_h, drq_h_oe, drq_d, drq_d_oe, dma_request_n;
  logic       cs_n, addr_select, ale, master_reset_n, host_irq;

  assign data           = data_h_oe ? data_h : (data_d_oe ? data_d : 8'hFF);
  assign dp             = data_h_oe ? dp_h : (data_d_oe ? dp_d : 1'b1);
  assign read_strobe_n  = rs_h_oe ? rs_h : (rs_d_oe ? rs_d : 1'b1);
  assign write_strobe_n = ws_h_oe ? ws_h : (ws_d_oe ? ws_d : 1'b1);
  // in buffer mode this wire is the ram select
  assign dma_ack_n      = ack_h_oe ? ack_h : (sel_d_oe ? sel_d : 1'b1);
  assign dma_request_n  = drq_d_oe ? drq_d : (drq_h_oe ? drq_h : 1'b1);

  modport dev (
    input  data, dp, read_strobe_n, write_strobe_n, dma_ack_n, dma_request_n,
    input  cs_n, addr_select, ale, master_reset_n,
    output data_d, data_d_oe, dp_d, rs_d, rs_d_oe, ws_d, ws_d_oe,
    output sel_d, sel_d_oe, drq_d, drq_d_oe, host_irq
  );
  modport host (
    input  data, dp, read_strobe_n, write_strobe_n, dma_ack_n, dma_request_n, host_irq,
    output data_h, data_h_oe, dp_h, rs_h, rs_h_oe, ws_h, ws_h_oe,
    output ack_h, ack_h_oe, drq_h, drq_h_oe, cs_n, addr_select, ale, master_reset_n
  );
endinterface
`default_nettype wire

// file: verilog/scsihp_fall.sv
/*
  falling-edge detector for an active-low strobe.
  assumes the level is already synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module scsihp_fall (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // strobe
  input  wire logic level_n,
  output logic      fall
);
  logic prev_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= level_n;
    end
  end

  assign fall = prev_r & ~level_n;
endmodule
`default_nettype wire

// file: verilog/scsihp_dev.sv
/*
  controller end of the host/dma port: indirect and multiplexed register
  access, single and burst dma, direct buffer mode, interrupt request.
  assumes pin inputs synchronous to clk and a scsi engine on the user side.
*/
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module scsihp_dev (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // processor/dma pins
  scsihp_if.dev           pin,
  // scsi engine events
  input  wire logic       cmd_done,
  input  wire logic [7:0] cmd_status,
  input  wire logic       sel_done,
  input  wire logic       arb_lost,
  input  wire logic       phase_req,
  input  wire logic       scsi_drive_req,
  // scsi engine data
  input  wire logic       xfer_in_valid,
  input  wire logic [7:0] xfer_in_data,
  output logic [7:0]      xfer_out_data_r,
  output logic            xfer_out_valid_r,
  // scsi engine control
  output logic            arb_retry_r,
  output logic            scsi_oe_r,
  output logic [3:0]      sync_offset_r,
  output logic            parity_err_r
);
  typedef enum logic [1:0] {
    BF_IDLE  = 2'b00,
    BF_SETUP = 2'b01,
    BF_LOW1  = 2'b10,
    BF_LOW2  = 2'b11
  } scsihp_buf_type;

  logic           rst_meta_r, rst_r, rd_fall, wr_fall;
  logic [4:0]     ptr_r;
  logic [7:0]     ctrl_r, data_r, status_r, rd_mux;
  logic [4:0]     cnt_hi_r;
  logic [12:0]    count_r;
  logic           irq_r, rd_oe_r;
  scsihp_buf_type bf_r;

  wire raw_rst = reset | ~pin.master_reset_n;
  wire [1:0] mode = ctrl_r[scsihp_pkg::CTRL_MODE +: 2];
  wire dma_cyc = ((mode == scsihp_pkg::MODE_DMA) | (mode == scsihp_pkg::MODE_BURST)) & ~pin.dma_ack_n;
  wire [4:0] target = dma_cyc ? scsihp_pkg::REG_DATA : ptr_r;
  wire rd_go = rd_fall & ~pin.rs_d_oe & (~pin.cs_n | dma_cyc);
  wire wr_go = wr_fall & ~pin.ws_d_oe & (~pin.cs_n | dma_cyc);
  wire reg_wr = wr_go & (dma_cyc | pin.addr_select);
  wire reg_rd = rd_go & (dma_cyc | pin.addr_select);
  wire permit = (mode == scsihp_pkg::MODE_BUF) & pin.dma_request_n;
  wire to_buf = ctrl_r[scsihp_pkg::CTRL_DIR];
  wire buf_byte = (bf_r == BF_LOW2);
  wire dma_byte = dma_cyc & (reg_rd | reg_wr);
  wire par_bad = ctrl_r[scsihp_pkg::CTRL_PAR_EN] & ~(^{pin.dp, pin.data});
  wire stat_rd = reg_rd & (target == scsihp_pkg::REG_STATUS);
  wire err_rd = reg_rd & (target == scsihp_pkg::REG_ERR);
  wire irq_set = cmd_done | sel_done | phase_req;

  // reset applies at once, releases on a clock edge
  always_ff @(posedge clk or posedge raw_rst) begin
    if (raw_rst) begin
      rst_meta_r <= 1'b1;
      rst_r      <= 1'b1;
    end else begin
      rst_meta_r <= 1'b0;
      rst_r      <= rst_meta_r;
    end
  end

  scsihp_fall u_rd_fall (
    .clk     (clk),
    .reset   (rst_r),
    .level_n (pin.read_strobe_n),
    .fall    (rd_fall)
  );

  scsihp_fall u_wr_fall (
    .clk     (clk),
    .reset   (rst_r),
    .level_n (pin.write_strobe_n),
    .fall    (wr_fall)
  );

  // address pointer
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      ptr_r <= 5'h00;
    end else if (pin.ale) begin
      ptr_r <= pin.data[4:0];
    end else if (wr_go & ~dma_cyc & ~pin.addr_select) begin
      ptr_r <= pin.data[4:0];
    end
  end

  // control, offset and count registers
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      ctrl_r        <= scsihp_pkg::CTRL_RST;
      sync_offset_r <= scsihp_pkg::OFFSET_MIN;
      cnt_hi_r      <= 5'h00;
      count_r       <= 13'h0000;
    end else begin
      if (reg_wr & (target == scsihp_pkg::REG_CTRL)) begin
        ctrl_r <= pin.data;
      end
      if (reg_wr & (target == scsihp_pkg::REG_OFFSET)) begin
        if (pin.data[3:0] < scsihp_pkg::OFFSET_MIN) begin
          sync_offset_r <= scsihp_pkg::OFFSET_MIN;
        end else if ((pin.data[7:4] != 4'h0) | (pin.data[3:0] > scsihp_pkg::OFFSET_MAX)) begin
          sync_offset_r <= scsihp_pkg::OFFSET_MAX;
        end else begin
          sync_offset_r <= pin.data[3:0];
        end
      end
      if (reg_wr & (target == scsihp_pkg::REG_CNT_HI)) begin
        cnt_hi_r <= pin.data[4:0];
      end
      if (reg_wr & (target == scsihp_pkg::REG_CNT_LO)) begin
        // larger counts clamp to one full burst
        count_r <= ({cnt_hi_r, pin.data} > scsihp_pkg::COUNT_MAX) ? scsihp_pkg::COUNT_MAX
                                                                  : {cnt_hi_r, pin.data};
      end else if ((dma_byte | buf_byte) & (count_r != 13'h0000)) begin
        count_r <= count_r - 13'h0001;
      end
    end
  end

  // data register and byte stream toward the scsi engine
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      data_r           <= 8'h00;
      xfer_out_data_r  <= 8'h00;
      xfer_out_valid_r <= 1'b0;
    end else begin
      xfer_out_valid_r <= 1'b0;
      if (reg_wr & (target == scsihp_pkg::REG_DATA)) begin
        data_r           <= pin.data;
        xfer_out_data_r  <= pin.data;
        xfer_out_valid_r <= 1'b1;
      end else if (buf_byte & ~to_buf) begin
        data_r           <= pin.data;
        xfer_out_data_r  <= pin.data;
        xfer_out_valid_r <= 1'b1;
      end else if (xfer_in_valid) begin
        data_r <= xfer_in_data;
      end
    end
  end

  always_comb begin
    unique case (target)
      scsihp_pkg::REG_CTRL:   rd_mux = ctrl_r;
      scsihp_pkg::REG_OFFSET: rd_mux = {4'h0, sync_offset_r};
      scsihp_pkg::REG_CNT_HI: rd_mux = {3'h0, count_r[12:8]};
      scsihp_pkg::REG_CNT_LO: rd_mux = count_r[7:0];
      scsihp_pkg::REG_STATUS: rd_mux = status_r;
      scsihp_pkg::REG_DATA:   rd_mux = data_r;
      scsihp_pkg::REG_ERR:    rd_mux = {7'h00, parity_err_r};
      default:                rd_mux = 8'h00;
    endcase
  end

  // interrupt and status; a new event beats a clearing read
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      irq_r        <= 1'b0;
      status_r     <= 8'h00;
      arb_retry_r  <= 1'b0;
      parity_err_r <= 1'b0;
      scsi_oe_r    <= 1'b0;
    end else begin
      irq_r        <= irq_set | (irq_r & ~stat_rd);
      arb_retry_r  <= arb_lost;
      parity_err_r <= (reg_wr & par_bad) | (parity_err_r & ~err_rd);
      scsi_oe_r    <= scsi_drive_req;
      if (cmd_done) begin
        status_r <= cmd_status;
      end else if (sel_done) begin
        status_r <= scsihp_pkg::STAT_SEL;
      end else if (phase_req) begin
        status_r <= scsihp_pkg::STAT_PHASE;
      end
    end
  end

  assign pin.host_irq = irq_r;

  // buffer engine: select, strobe low two cycles, strobe high
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      bf_r        <= BF_IDLE;
      pin.sel_d   <= 1'b1;
      pin.rs_d    <= 1'b1;
      pin.ws_d    <= 1'b1;
      pin.rs_d_oe <= 1'b0;
      pin.ws_d_oe <= 1'b0;
    end else if (~permit | ((bf_r != BF_LOW1) & (bf_r != BF_LOW2) & (count_r == 13'h0000))) begin
      bf_r        <= BF_IDLE;
      pin.sel_d   <= 1'b1;
      pin.rs_d    <= 1'b1;
      pin.ws_d    <= 1'b1;
      pin.rs_d_oe <= 1'b0;
      pin.ws_d_oe <= 1'b0;
    end else begin
      unique case (bf_r)
        BF_IDLE: begin
          bf_r        <= BF_SETUP;
          pin.sel_d   <= 1'b0;
          pin.rs_d_oe <= 1'b1;
          pin.ws_d_oe <= 1'b1;
        end
        BF_SETUP: begin
          bf_r     <= BF_LOW1;
          pin.rs_d <= to_buf;
          pin.ws_d <= ~to_buf;
        end
        BF_LOW1: begin
          bf_r <= BF_LOW2;
        end
        BF_LOW2: begin
          bf_r     <= BF_SETUP;
          pin.rs_d <= 1'b1;
          pin.ws_d <= 1'b1;
        end
      endcase
    end
  end

  // data pins: register reads, or buffer writes
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      pin.data_d    <= 8'h00;
      pin.dp_d      <= 1'b1;
      pin.data_d_oe <= 1'b0;
      rd_oe_r       <= 1'b0;
    end else begin
      if (reg_rd) begin
        rd_oe_r    <= 1'b1;
        pin.data_d <= rd_mux;
        pin.dp_d   <= ~^rd_mux;
      end else if (pin.read_strobe_n) begin
        rd_oe_r <= 1'b0;
      end
      if (bf_r != BF_IDLE & to_buf) begin
        pin.data_d <= data_r;
        pin.dp_d   <= ~^data_r;
      end
      pin.data_d_oe <= (reg_rd | (rd_oe_r & ~pin.read_strobe_n)) | ((bf_r != BF_IDLE) & permit & to_buf);
    end
  end

  // request pin: driven in dma modes, an input in buffer mode
  always_ff @(posedge clk or posedge rst_r) begin
    if (rst_r) begin
      pin.drq_d     <= 1'b1;
      pin.drq_d_oe  <= 1'b0;
      pin.sel_d_oe  <= 1'b0;
    end else begin
      pin.drq_d_oe <= (mode == scsihp_pkg::MODE_DMA) | (mode == scsihp_pkg::MODE_BURST);
      pin.sel_d_oe <= (mode == scsihp_pkg::MODE_BUF);
      if (mode == scsihp_pkg::MODE_BURST) begin
        pin.drq_d <= (count_r == 13'h0000);
      end else if (mode == scsihp_pkg::MODE_DMA) begin
        pin.drq_d <= (count_r == 13'h0000) | ~pin.dma_ack_n;
      end else begin
        pin.drq_d <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/scsihp_host.sv
/*
  processor/dma partner end: turns orders written into its command registers
  into pin cycles, indirect or multiplexed, answers dma requests, and acts as
  the sector buffer in buffer mode. assumes a plain register port user.
*/
`timescale 1ns/100ps
`default_nettype none
module scsihp_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // command port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata_r,
  // pins
  scsihp_if.host          pin
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ALE  = 3'b001,
    HS_PTR  = 3'b010,
    HS_GAP  = 3'b011,
    HS_ACC  = 3'b100,
    HS_DMA  = 3'b101,
    HS_REL  = 3'b110
  } scsihp_hst_type;

  logic [7:0]     haddr_r, hwdata_r, hctrl_r, hrdata_r;
  logic           pend_rd_r, pend_wr_r, is_wr_r;
  logic [1:0]     step_r;
  scsihp_hst_type st_r;

  wire mux_bus = hctrl_r[scsihp_pkg::HC_MUX];
  wire buf_md = hctrl_r[scsihp_pkg::HC_BUF];
  wire busy = (st_r != HS_IDLE) | pend_rd_r | pend_wr_r;
  wire go = wr & (addr == scsihp_pkg::H_GO);
  wire held = (step_r == scsihp_pkg::HOLD_LAST);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      haddr_r  <= 8'h00;
      hwdata_r <= 8'h00;
      hctrl_r  <= 8'h00;
      rdata_r  <= 8'h00;
    end else begin
      if (wr & (addr == scsihp_pkg::H_ADDR)) begin
        haddr_r <= wdata;
      end
      if (wr & (addr == scsihp_pkg::H_WDATA)) begin
        hwdata_r <= wdata;
      end
      if (wr & (addr == scsihp_pkg::H_CTRL)) begin
        hctrl_r <= wdata;
      end
      if (rd) begin
        unique case (addr)
          scsihp_pkg::H_ADDR:   rdata_r <= haddr_r;
          scsihp_pkg::H_WDATA:  rdata_r <= hwdata_r;
          scsihp_pkg::H_CTRL:   rdata_r <= hctrl_r;
          scsihp_pkg::H_STATUS: rdata_r <= {6'h00, pin.host_irq, busy};
          scsihp_pkg::H_RDATA:  rdata_r <= hrdata_r;
          default:              rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // fixed pin roles follow the mode bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin.master_reset_n <= 1'b0;
      pin.rs_h_oe        <= 1'b0;
      pin.ws_h_oe        <= 1'b0;
      pin.ack_h_oe       <= 1'b0;
      pin.drq_h_oe       <= 1'b0;
      pin.drq_h          <= 1'b1;
    end else begin
      pin.master_reset_n <= ~hctrl_r[scsihp_pkg::HC_SOFTRST];
      pin.rs_h_oe        <= ~buf_md;
      pin.ws_h_oe        <= ~buf_md;
      pin.ack_h_oe       <= ~buf_md;
      // held low outside buffer use, so a buffer-mode device engine waits for us
      pin.drq_h_oe       <= ~hctrl_r[scsihp_pkg::HC_DMA];
      pin.drq_h          <= buf_md & hctrl_r[scsihp_pkg::HC_PERMIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r            <= HS_IDLE;
      step_r          <= 2'h0;
      pend_rd_r       <= 1'b0;
      pend_wr_r       <= 1'b0;
      is_wr_r         <= 1'b0;
      hrdata_r        <= 8'h00;
      pin.cs_n        <= 1'b1;
      pin.addr_select <= 1'b1;
      pin.ale         <= 1'b0;
      pin.rs_h        <= 1'b1;
      pin.ws_h        <= 1'b1;
      pin.ack_h       <= 1'b1;
      pin.data_h      <= 8'h00;
      pin.dp_h        <= 1'b1;
      pin.data_h_oe   <= 1'b0;
    end else begin
      step_r <= held ? step_r : step_r + 2'h1;
      if (go) begin
        pend_rd_r <= wdata[scsihp_pkg::GO_RD];
        pend_wr_r <= wdata[scsihp_pkg::GO_WR] & ~wdata[scsihp_pkg::GO_RD];
      end
      unique case (st_r)
        HS_IDLE: begin
          step_r        <= 2'h0;
          pin.data_h_oe <= 1'b0;
          if (buf_md) begin
            // sector buffer role: serve reads, capture writes
            pin.data_h    <= hwdata_r;
            pin.dp_h      <= ~^hwdata_r;
            pin.data_h_oe <= ~pin.dma_ack_n & ~pin.read_strobe_n;
            if (~pin.dma_ack_n & ~pin.write_strobe_n) begin
              hrdata_r <= pin.data;
            end
          end else if ((pend_rd_r | pend_wr_r) & ~go) begin
            is_wr_r       <= pend_wr_r;
            pend_rd_r     <= 1'b0;
            pend_wr_r     <= 1'b0;
            pin.data_h    <= haddr_r;
            pin.dp_h      <= ~^haddr_r;
            pin.data_h_oe <= 1'b1;
            if (mux_bus) begin
              st_r    <= HS_ALE;
              pin.ale <= 1'b1;
            end else begin
              st_r            <= HS_PTR;
              pin.cs_n        <= 1'b0;
              pin.addr_select <= 1'b0;
              pin.ws_h        <= 1'b0;
            end
          end else if (hctrl_r[scsihp_pkg::HC_DMA] & ~pin.dma_request_n) begin
            st_r          <= HS_DMA;
            is_wr_r       <= hctrl_r[scsihp_pkg::HC_DMA_WR];
            pin.cs_n      <= 1'b1;
            pin.ack_h     <= 1'b0;
            pin.rs_h      <= hctrl_r[scsihp_pkg::HC_DMA_WR];
            pin.ws_h      <= ~hctrl_r[scsihp_pkg::HC_DMA_WR];
            pin.data_h    <= hwdata_r;
            pin.dp_h      <= ~^hwdata_r;
            pin.data_h_oe <= hctrl_r[scsihp_pkg::HC_DMA_WR];
          end
        end
        HS_ALE: begin
          st_r    <= HS_GAP;
          pin.ale <= 1'b0;
        end
        HS_PTR: begin
          if (held) begin
            st_r            <= HS_GAP;
            pin.ws_h        <= 1'b1;
            pin.cs_n        <= 1'b1;
            pin.addr_select <= 1'b1;
            pin.data_h_oe   <= 1'b0;
          end
        end
        HS_GAP: begin
          st_r            <= HS_ACC;
          step_r          <= 2'h0;
          pin.cs_n        <= 1'b0;
          pin.addr_select <= 1'b1;
          pin.rs_h        <= is_wr_r;
          pin.ws_h        <= ~is_wr_r;
          pin.data_h      <= hwdata_r;
          pin.dp_h        <= ~^hwdata_r;
          pin.data_h_oe   <= is_wr_r;
        end
        HS_ACC, HS_DMA: begin
          if (held) begin
            st_r          <= HS_REL;
            pin.cs_n      <= 1'b1;
            pin.ack_h     <= 1'b1;
            pin.rs_h      <= 1'b1;
            pin.ws_h      <= 1'b1;
            pin.data_h_oe <= 1'b0;
            if (~is_wr_r) begin
              hrdata_r <= pin.data;
            end
          end
        end
        HS_REL: begin
          st_r <= HS_IDLE;
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verilog/scsihp_dummy_none.sv
`timescale 1ns/100ps

// file: bench/scsihp_chk.sv
/* link checker for the scsi host/dma port.
   assumes plain inputs tied to the link signals, one clock, reset high. */
`timescale 1ns/100ps
`default_nettype none
module scsihp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic dma_ack_n,
  input wire logic dma_request_n,
  input wire logic master_reset_n,
  input wire logic host_irq,
  input wire logic data_d_oe,
  input wire logic rs_d,
  input wire logic rs_d_oe,
  input wire logic ws_d,
  input wire logic ws_d_oe,
  input wire logic sel_d_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_dev_strobe;
    (rs_d_oe && !rs_d) || (ws_d_oe && !ws_d);
  endsequence
  sequence s_buf_held;
    sel_d_oe && !dma_ack_n && !dma_request_n;
  endsequence
  a_reset_float: assert property (
    !master_reset_n |-> !(data_d_oe || rs_d_oe || ws_d_oe || sel_d_oe || host_irq)) else $error("driven in reset");
  // release is synchronised, so the port stays quiet two edges
  a_reset_quiet: assert property (
    $rose(master_reset_n) |-> !(data_d_oe || sel_d_oe) [*2]) else $error("early drive");
  a_read_qualify: assert property (
    $rose(data_d_oe) && !sel_d_oe |-> !$past(read_strobe_n) && (!$past(cs_n) || !$past(dma_ack_n)))
    else $error("unqualified read");
  a_read_release: assert property (
    data_d_oe && read_strobe_n && !sel_d_oe && !$past(sel_d_oe) |=> !data_d_oe) else $error("bus held");
  // irq may only drop from a status read or a reset
  a_irq_drop: assert property (
    $fell(host_irq) |-> !master_reset_n || !$past(read_strobe_n) || !$past(read_strobe_n, 2)
    || !$past(read_strobe_n, 3)) else $error("irq lost");
  a_host_cs_off: assert property (
    !dma_ack_n |-> cs_n) else $error("select in dma cycle");
  a_buf_strobe: assert property (
    s_dev_strobe |-> !dma_ack_n) else $error("strobe without ram select");
  a_buf_inhibit: assert property (
    s_buf_held |-> ##[1:2] dma_ack_n) else $error("select kept");
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/* bench for the scsi host/dma port: host end and controller end joined by
   the link. assumes each end idles within a few cycles of reset. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       clk, reset, wr, rd, cmd_done, sel_done, arb_lost, phase_req;
  logic       scsi_drive_req, xfer_in_valid, xfer_out_valid_r, arb_retry_r, scsi_oe_r;
  logic [2:0] addr;
  logic [3:0] sync_offset_r;
  logic [7:0] wdata, rdata_r, cmd_status, xfer_in_data, xfer_out_data_r, last_out;
  int         n_errors, n_compared, n_out;
  scsihp_if link ();
  scsihp_host u_scsihp_host (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata_r, .pin(link.host));
  scsihp_dev u_scsihp_dev (.clk, .reset, .pin(link.dev), .cmd_done, .cmd_status, .sel_done, .arb_lost,
    .phase_req, .scsi_drive_req, .xfer_in_valid, .xfer_in_data, .xfer_out_data_r, .xfer_out_valid_r,
    .arb_retry_r, .scsi_oe_r, .sync_offset_r, .parity_err_r());
  scsihp_chk u_chk (.clk, .reset, .cs_n(link.cs_n), .read_strobe_n(link.read_strobe_n),
    .dma_ack_n(link.dma_ack_n), .dma_request_n(link.dma_request_n), .master_reset_n(link.master_reset_n),
    .host_irq(link.host_irq), .data_d_oe(link.data_d_oe), .rs_d(link.rs_d), .rs_d_oe(link.rs_d_oe),
    .ws_d(link.ws_d), .ws_d_oe(link.ws_d_oe), .sel_d_oe(link.sel_d_oe));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (xfer_out_valid_r) {n_out, last_out} <= {n_out + 1, xfer_out_data_r};
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic cr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata_r;
  endtask
  task automatic feed(input logic [7:0] d);
    @(posedge clk);
    xfer_in_valid <= 1'h1;
    xfer_in_data <= d;
    @(posedge clk);
    xfer_in_valid <= 1'h0;
  endtask
  // one device register cycle; polls busy under a bound so a hang shows
  task automatic acc(input logic [4:0] p, input logic [7:0] d, input logic w, output logic [7:0] q);
    logic [7:0] s;
    s = 8'h01;
    cw(scsihp_pkg::H_ADDR, {3'h0, p});
    cw(scsihp_pkg::H_WDATA, d);
    cw(scsihp_pkg::H_GO, w ? 8'h02 : 8'h01);
    for (int i = 0; i < 40 && s[0]; i++) cr(scsihp_pkg::H_STATUS, s);
    chk("busy", {7'h0, s[0]}, 8'h00);
    cr(scsihp_pkg::H_RDATA, q);
  endtask
  task automatic t_offset;
    logic [7:0] d[4] = '{8'h00, 8'h01, 8'h0C, 8'h0D};
    logic [7:0] q;
    foreach (d[i]) begin
      acc(scsihp_pkg::REG_OFFSET, d[i], 1'h1, q);
      chk("offset", {4'h0, sync_offset_r}, d[i] < 8'h01 ? 8'h01 : (d[i] > 8'h0C ? 8'h0C : d[i]));
    end
  endtask
  task automatic t_data;
    logic [7:0] q;
    for (int m = 0; m < 2; m++) begin
      cw(scsihp_pkg::H_CTRL, 8'(m));
      feed(8'hA0 | 8'(m));
      acc(scsihp_pkg::REG_DATA, 8'h00, 1'h0, q);
      chk("data read", q, 8'hA0 | 8'(m));
      acc(scsihp_pkg::REG_DATA, 8'h3C ^ 8'(m), 1'h1, q);
      chk("data write", last_out, 8'h3C ^ 8'(m));
    end
    cw(scsihp_pkg::H_CTRL, 8'h00);
  endtask
  task automatic t_irq;
    logic [7:0] q;
    logic [7:0] e[3] = '{8'h42, scsihp_pkg::STAT_SEL, scsihp_pkg::STAT_PHASE};
    @(posedge clk);
    arb_lost <= 1'h1;
    @(posedge clk);
    arb_lost <= 1'h0;
    #1 chk("retry", {7'h0, arb_retry_r}, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk("irq quiet", {7'h0, link.host_irq}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cmd_status <= 8'h42;
      {cmd_done, sel_done, phase_req} <= 3'h4 >> k;
      @(posedge clk);
      {cmd_done, sel_done, phase_req} <= 3'h0;
      repeat (4) @(posedge clk);
      #1 chk("irq set", {7'h0, link.host_irq}, 8'h01);
      acc(scsihp_pkg::REG_STATUS, 8'h00, 1'h0, q);
      chk("status", q, e[k]);
      chk("irq clear", {7'h0, link.host_irq}, 8'h00);
    end
  endtask
  task automatic t_dma;
    logic [7:0] q;
    int n0 = n_out;
    cw(scsihp_pkg::H_CTRL, 8'h0C);
    acc(scsihp_pkg::REG_CTRL, 8'h02, 1'h1, q);
    acc(scsihp_pkg::REG_CNT_LO, 8'h02, 1'h1, q);
    repeat (20) @(posedge clk);
    chk("dma bytes", 8'(n_out - n0), 8'h02);
    chk("dma byte", last_out, 8'h02);
    acc(scsihp_pkg::REG_CTRL, 8'h00, 1'h1, q);
    cw(scsihp_pkg::H_CTRL, 8'h00);
  endtask
  task automatic t_reset;
    @(posedge clk);
    scsi_drive_req <= 1'h1;
    cw(scsihp_pkg::H_CTRL, 8'h20);
    #1 chk("scsi drive", {7'h0, scsi_oe_r}, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("scsi float", {7'h0, scsi_oe_r}, 8'h00);
    cw(scsihp_pkg::H_CTRL, 8'h00);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_buf;
    logic [7:0] q;
    feed(8'h96);
    acc(scsihp_pkg::REG_CNT_HI, 8'h01, 1'h1, q);
    acc(scsihp_pkg::REG_CNT_LO, 8'h03, 1'h1, q);
    acc(scsihp_pkg::REG_CTRL, 8'h0B, 1'h1, q);
    cw(scsihp_pkg::H_CTRL, 8'h12);
    #1;
    for (int i = 0; i < 40 && link.dma_ack_n !== 1'h0; i++) #5;
    chk("select on", {7'h0, link.dma_ack_n}, 8'h00);
    repeat (8) @(posedge clk);
    cw(scsihp_pkg::H_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk("select off", {7'h0, link.dma_ack_n}, 8'h01);
    cr(scsihp_pkg::H_RDATA, q);
    chk("buffer byte", q, 8'h96);
  endtask
  initial begin
    reset = 1'h1;
    {wr, rd, cmd_done, sel_done, arb_lost, phase_req, scsi_drive_req, xfer_in_valid} = 8'h00;
    {addr, wdata, cmd_status, xfer_in_data} = 27'h0;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    #1 chk("irq reset", {7'h0, link.host_irq}, 8'h00);
    t_offset;
    t_data;
    t_irq;
    t_dma;
    t_buf;
    t_reset;
    end_sim;
  end
  initial begin
    #60000;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
